/* fmc_pkg.sv */
// Functional notes
// - Setup, read, command entry and busy modes; reset starts in power-on setup, then read
// - Return to read after reset/completed command
// - Back in read soon after CPU reset
// - Bad address, data or order aborts
// - Write to read-protected flash aborts
// - Read mode holds until the first unlock write
// - Read returns one 32-bit double word
// - Reads aligned; address bits 1:0 ignored
// - Top three address bits pick segment
// - Step decoded from address, data and state
// - Controller starts on last write; erase when confirm window expires
// - Busy shown by status and ready/busy
// - Commands are several writes to fixed addresses
// - Erase confirms must beat a timed window
// - Array unreadable during power-on setup
package fmc_pkg;

  // Address and data widths
  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 32;
  localparam int CMD_W      = 16;
  localparam int SEG_LSB    = 16;
  localparam int WORD_LSB   = 2;

  // Command unlock addresses and codes (byte addresses within the array)
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h05554;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h02AA8;
  localparam logic [CMD_W-1:0]  UNLOCK_DATA_A = 16'h00A8;
  localparam logic [CMD_W-1:0]  UNLOCK_DATA_B = 16'h0054;
  localparam logic [CMD_W-1:0]  CODE_RESET    = 16'h00F0;
  localparam logic [CMD_W-1:0]  CODE_PROGRAM  = 16'h00A0;
  localparam logic [CMD_W-1:0]  CODE_ERASE    = 16'h0080;
  localparam logic [CMD_W-1:0]  CODE_CONFIRM  = 16'h0030;
  localparam logic [CMD_W-1:0]  CODE_PROTECT  = 16'h00C0;
  localparam logic [CMD_W-1:0]  CODE_UNPROT   = 16'h00C1;

  // Operation codes handed to the array
  localparam logic [2:0] OP_NONE    = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE   = 3'h2;
  localparam logic [2:0] OP_PROTECT = 3'h3;
  localparam logic [2:0] OP_UNPROT  = 3'h4;

  // Status register layout
  localparam int ST_BUSY  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_ERASE = 2;
  localparam int ST_W     = 8;
  localparam logic [ST_W-1:0] STATUS_RESET = 8'h00;

  // Timing
  localparam int CLK_HZ            = 40_000_000;
  localparam int ERASE_WINDOW_NS   = 96_000;
  localparam int ERASE_WINDOW_CYC  = ERASE_WINDOW_NS / (1_000_000_000 / CLK_HZ);
  localparam int SETUP_NS          = 5_000;
  localparam int SETUP_CYC         = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MAX_ERASE_BLOCKS  = 11;

  typedef enum logic [3:0] {
    FMC_SETUP, FMC_READ, FMC_UNLOCK1, FMC_UNLOCK2, FMC_SELECT,
    FMC_EUNLOCK1, FMC_EUNLOCK2, FMC_EUNLOCK3, FMC_PROG_DATA,
    FMC_ECONFIRM, FMC_BLOCK_SEL, FMC_BUSY
  } fmc_state_e;

endpackage

/* fmc_flash_mode_controller.sv */
`timescale 1ns/10ps
module fmc_flash_mode_controller
  import fmc_pkg::*;
(
  // System
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              cpu_reset,
  // CPU read port
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic                   rd_ack,
  output logic [DATA_W-1:0]      rd_data,
  // CPU command write port
  input  wire logic              wr_req,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [CMD_W-1:0]  wr_data,
  // Protection and array interface
  input  wire logic              read_protected,
  output logic                   array_rd_en,
  output logic [2:0]             array_rd_seg,
  output logic [SEG_LSB-3:0]     array_rd_word,
  input  wire logic [DATA_W-1:0] array_rd_data,
  output logic                   op_start,
  output logic [2:0]             op_code,
  output logic [ADDR_W-1:0]      op_addr,
  output logic [CMD_W-1:0]       op_data,
  input  wire logic              op_done,
  input  wire logic              op_fail,
  // Status
  output logic                   read_mode,
  output logic                   ready_busy_n,
  output logic [ST_W-1:0]        status,
  output logic                   hold_cpu_reset,
  input  wire logic              external_boot_select
);

  fmc_state_e            state;
  logic [15:0]           setup_cnt;
  logic [15:0]           erase_cnt;
  logic                  cmd_abort;
  logic                  last_write;
  logic [2:0]            next_op;

  // Command decoder: step comes from the address, the data and the present state
  always_comb begin
    cmd_abort  = 1'b0;
    last_write = 1'b0;
    next_op    = OP_NONE;
    if (wr_req && state != FMC_SETUP && state != FMC_BUSY) begin
      if (read_protected) begin
        cmd_abort = 1'b1;
      end else begin
        case (state)
          FMC_READ, FMC_EUNLOCK1:
            cmd_abort = !(wr_addr == UNLOCK_ADDR_A && wr_data == UNLOCK_DATA_A)
                        && wr_data != CODE_RESET;
          FMC_UNLOCK1, FMC_EUNLOCK2:
            cmd_abort = !(wr_addr == UNLOCK_ADDR_B && wr_data == UNLOCK_DATA_B);
          FMC_SELECT:
            cmd_abort = wr_addr != UNLOCK_ADDR_A ||
                        !(wr_data == CODE_PROGRAM || wr_data == CODE_ERASE ||
                          wr_data == CODE_PROTECT || wr_data == CODE_UNPROT);
          FMC_EUNLOCK3:
            cmd_abort = wr_data != CODE_CONFIRM;
          FMC_PROG_DATA: begin
            last_write = 1'b1;
            next_op    = OP_PROGRAM;
          end
          FMC_BLOCK_SEL: begin
            last_write = 1'b1;
            next_op    = (op_code == OP_UNPROT) ? OP_UNPROT : OP_PROTECT;
          end
          FMC_ECONFIRM:
            cmd_abort = wr_data != CODE_CONFIRM;
          default:
            cmd_abort = 1'b1;
        endcase
      end
    end
  end

  // Mode sequencer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= FMC_SETUP;
    end else if (cpu_reset && state != FMC_SETUP) begin
      state <= FMC_READ;
    end else begin
      case (state)
        FMC_SETUP:
          if (setup_cnt == 16'(SETUP_CYC - 1)) state <= FMC_READ;
        FMC_BUSY:
          if (op_done) state <= FMC_READ;
        FMC_ECONFIRM:
          if (cmd_abort) state <= FMC_READ;
          else if (erase_cnt == 16'd0) state <= FMC_BUSY;
        default:
          if (cmd_abort) state <= FMC_READ;
          else if (wr_req && wr_data == CODE_RESET && state == FMC_READ)
            state <= FMC_READ;
          else if (last_write) state <= FMC_BUSY;
          else if (wr_req) begin
            case (state)
              FMC_READ:     state <= FMC_UNLOCK1;
              FMC_UNLOCK1:  state <= FMC_SELECT;
              FMC_SELECT:   state <= (wr_data == CODE_PROGRAM) ? FMC_PROG_DATA :
                                     (wr_data == CODE_ERASE) ? FMC_EUNLOCK1 : FMC_BLOCK_SEL;
              FMC_EUNLOCK1: state <= FMC_EUNLOCK2;
              FMC_EUNLOCK2: state <= FMC_EUNLOCK3;
              FMC_EUNLOCK3: state <= FMC_ECONFIRM;
              default:      state <= FMC_READ;
            endcase
          end
      endcase
    end
  end

  // Power-on setup counter
  always_ff @(posedge clk_sys) begin
    if (reset) setup_cnt <= 16'h0000;
    else if (state == FMC_SETUP) setup_cnt <= setup_cnt + 16'h0001;
  end

  // Erase confirm window, restarted by each confirm; no pause allowed
  always_ff @(posedge clk_sys) begin
    if (reset) erase_cnt <= 16'h0000;
    else if (wr_req && !cmd_abort && (state == FMC_EUNLOCK3 || state == FMC_ECONFIRM))
      erase_cnt <= 16'(ERASE_WINDOW_CYC - 1);
    else if (erase_cnt != 16'h0000) erase_cnt <= erase_cnt - 16'h0001;
  end

  // Operation hand-off to the erase/program controller
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_start <= 1'b0;
      op_code  <= OP_NONE;
      op_addr  <= '0;
      op_data  <= 16'h0000;
    end else begin
      op_start <= 1'b0;
      if (state == FMC_SELECT && wr_req && !cmd_abort)
        op_code <= (wr_data == CODE_UNPROT) ? OP_UNPROT : OP_NONE;
      if (last_write && !cpu_reset) begin
        op_start <= 1'b1;
        op_code  <= next_op;
        op_addr  <= wr_addr;
        op_data  <= wr_data;
      end else if (state == FMC_ECONFIRM && !cmd_abort && erase_cnt == 16'h0000
                   && !cpu_reset) begin
        op_start <= 1'b1;
        op_code  <= OP_ERASE;
      end
      // Each erase confirm names the block; keep it for the launch
      if ((state == FMC_ECONFIRM || state == FMC_EUNLOCK3) && wr_req && !cmd_abort) begin
        op_addr <= wr_addr;
        op_data <= wr_data;
      end
    end
  end

  // Status register; sticky error cleared by the next launch
  always_ff @(posedge clk_sys) begin
    if (reset) status <= STATUS_RESET;
    else begin
      status[ST_BUSY]  <= (state == FMC_BUSY) && !op_done;
      status[ST_ERASE] <= (state == FMC_BUSY) && op_code == OP_ERASE;
      if (state == FMC_BUSY && op_done && op_fail) status[ST_ERR] <= 1'b1;
      else if (op_start) status[ST_ERR] <= 1'b0;
    end
  end

  // Array reads, only in read mode; word aligned, segment from top bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_ack        <= 1'b0;
      rd_data       <= 32'h00000000;
      array_rd_en   <= 1'b0;
      array_rd_seg  <= 3'h0;
      array_rd_word <= '0;
    end else begin
      array_rd_en <= rd_req && state == FMC_READ;
      rd_ack      <= array_rd_en;
      if (rd_req && state == FMC_READ) begin
        array_rd_seg  <= rd_addr[ADDR_W-1:SEG_LSB];
        array_rd_word <= rd_addr[SEG_LSB-1:WORD_LSB];
      end
      if (array_rd_en) rd_data <= array_rd_data;
    end
  end

  assign read_mode      = state == FMC_READ;
  assign ready_busy_n   = state != FMC_BUSY;
  assign hold_cpu_reset = external_boot_select && state == FMC_SETUP;

endmodule

/* fmc_props.sv */
`timescale 1ns/10ps
module fmc_props
  import fmc_pkg::*;
(
  // Watched ports
  input wire logic clk_sys, reset, cpu_reset, rd_req, rd_ack, wr_req, read_protected,
  input wire logic array_rd_en, op_start, op_done, read_mode, ready_busy_n, hold_cpu_reset,
  input wire logic external_boot_select,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data, array_rd_data,
  input wire logic [2:0] array_rd_seg,
  input wire logic [SEG_LSB-3:0] array_rd_word,
  input wire logic [ST_W-1:0] status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Read: array fetch one cycle after the request, answer the cycle after
  sequence s_fetch;
    array_rd_en && array_rd_seg == $past(rd_addr[18:16]) && array_rd_word == $past(rd_addr[15:2]);
  endsequence
  sequence s_ack;
    rd_ack && rd_data == $past(array_rd_data);
  endsequence
  property p_fetch; rd_req && read_mode |=> s_fetch; endproperty
  property p_ack; rd_req && read_mode |=> ##1 s_ack; endproperty
  property p_launch; op_start |-> !read_mode ##1 (!ready_busy_n && status[ST_BUSY]); endproperty
  property p_prior; op_start |-> $past(!read_mode); endproperty
  property p_done; op_done && !ready_busy_n |=> read_mode && ready_busy_n; endproperty
  property p_stay; !ready_busy_n && !op_done && !cpu_reset |=> !ready_busy_n; endproperty
  property p_cpu; cpu_reset && !ready_busy_n |=> read_mode; endproperty
  property p_prot; wr_req && read_protected && ready_busy_n |=> read_mode; endproperty
  property p_modes; read_mode |-> ready_busy_n && !hold_cpu_reset; endproperty
  property p_hold; hold_cpu_reset |-> external_boot_select && !read_mode; endproperty
  a_fetch: assert property (p_fetch) else $error("array fetch wrong");
  a_ack: assert property (p_ack) else $error("read answer wrong");
  a_launch: assert property (p_launch) else $error("launch not busy");
  a_prior: assert property (p_prior) else $error("launch from read");
  a_done: assert property (p_done) else $error("no return to read");
  a_stay: assert property (p_stay) else $error("busy dropped early");
  a_cpu: assert property (p_cpu) else $error("cpu reset ignored");
  a_prot: assert property (p_prot) else $error("protected write kept");
  a_modes: assert property (p_modes) else $error("mode overlap");
  a_hold: assert property (p_hold) else $error("hold wrong");
endmodule
bind fmc_flash_mode_controller fmc_props u_props (.*);

/* fmc_array_model.sv */
`timescale 1ns/10ps
module fmc_array_model
  import fmc_pkg::*;
(
  // Array and operation side
  input  wire logic               clk_sys, reset, array_rd_en, op_start, fail_next,
  input  wire logic [2:0]         array_rd_seg,
  input  wire logic [SEG_LSB-3:0] array_rd_word,
  output logic [DATA_W-1:0]       array_rd_data,
  output logic                    op_done, op_fail
);
  int cnt;
  // Idle cycles show the inverse, so a stale sample cannot match
  assign array_rd_data = array_rd_en ? {15'h2A5A, array_rd_seg, array_rd_word}
                                     : ~{15'h2A5A, array_rd_seg, array_rd_word};
  // Operation lasts 20 cycles, then a one-cycle completion
  always_ff @(posedge clk_sys) begin
    op_done <= 1'b0;
    op_fail <= 1'b0;
    if (reset) cnt <= 0;
    else if (op_start) cnt <= 20;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      op_done <= (cnt == 1);
      op_fail <= (cnt == 1) && fail_next;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import fmc_pkg::*;
  logic clk_sys = 0, reset = 1, cpu_reset = 0, rd_req = 0, wr_req = 0, read_protected = 0;
  logic external_boot_select = 1, fail_next = 0;
  logic rd_ack, op_start, op_done, op_fail, read_mode, ready_busy_n, hold_cpu_reset, array_rd_en;
  logic [ADDR_W-1:0] rd_addr = '0, wr_addr = '0, op_addr, a;
  logic [CMD_W-1:0] wr_data = '0, op_data;
  logic [DATA_W-1:0] rd_data, array_rd_data;
  logic [2:0] array_rd_seg, op_code;
  logic [SEG_LSB-3:0] array_rd_word;
  logic [ST_W-1:0] status;
  logic [39:0] exp_q[$];
  int err_total = 0, checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  fmc_flash_mode_controller uut (.*);
  fmc_array_model far_end (.*);
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_read(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_sys);
      if (read_mode === 1'b1) return;
    end
    err_total++;
    give_verdict();
  endtask
  // Every non-read operation is started by command writes
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [CMD_W-1:0] d);
    @(negedge clk_sys);
    wr_addr = ad;
    wr_data = d;
    wr_req = 1;
    @(negedge clk_sys);
    wr_req = 0;
  endtask
  task automatic unlock();
    wr(UNLOCK_ADDR_A, UNLOCK_DATA_A);
    wr(UNLOCK_ADDR_B, UNLOCK_DATA_B);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad);
    @(negedge clk_sys);
    rd_addr = ad;
    rd_req = 1;
    exp_q.push_back({8'h00, 15'h2A5A, ad[18:16], ad[15:2]});
    @(negedge clk_sys);
    rd_req = 0;
    repeat (3) @(negedge clk_sys);
  endtask
  // Results are matched in order against the notes left by the driver
  always @(posedge clk_sys) begin
    if (rd_ack === 1'b1) chk({8'h00, rd_data}, exp_q.size() ? exp_q.pop_front() : '1);
    if (op_start === 1'b1)
      chk({2'b01, op_code, op_addr, op_data}, exp_q.size() ? exp_q.pop_front() : '1);
  end
  // Main sequence
  initial begin
    void'($urandom(32'h3A3A2554));
    repeat (3) @(negedge clk_sys);
    reset = 0;
    @(negedge clk_sys);
    chk(hold_cpu_reset, 1);
    wait_read(300);
    chk(hold_cpu_reset, 0);
    for (int i = 0; i < 6; i++) rd(ADDR_W'($urandom));
    a = ADDR_W'($urandom);
    unlock();
    wr(UNLOCK_ADDR_A, CODE_PROGRAM);
    exp_q.push_back({2'b01, OP_PROGRAM, a, 16'h1234});
    wr(a, 16'h1234);
    wait_read(100);
    for (int i = 0; i < 2; i++) begin
      fail_next = i[0];
      unlock();
      wr(UNLOCK_ADDR_A, i ? CODE_UNPROT : CODE_PROTECT);
      exp_q.push_back({2'b01, i ? OP_UNPROT : OP_PROTECT, 19'h30000, 16'h0000});
      wr(19'h30000, 16'h0000);
      wait_read(100);
      chk(status[ST_ERR], i[0]);
    end
    unlock();
    wr(UNLOCK_ADDR_A, CODE_ERASE);
    unlock();
    wr(19'h20000, CODE_CONFIRM);
    exp_q.push_back({2'b01, OP_ERASE, 19'h20000, CODE_CONFIRM});
    wr(19'h20000, CODE_CONFIRM);
    repeat (3800) @(negedge clk_sys);
    chk(ready_busy_n, 1);
    wait_read(200);
    wr(UNLOCK_ADDR_A, UNLOCK_DATA_A);
    wr(UNLOCK_ADDR_B, 16'h0055);
    chk(read_mode, 1);
    wr(UNLOCK_ADDR_B, UNLOCK_DATA_B);
    chk(read_mode, 1);
    rd(19'h10007);
    read_protected = 1;
    unlock();
    chk(read_mode, 1);
    read_protected = 0;
    unlock();
    wr(UNLOCK_ADDR_A, CODE_RESET);
    chk(read_mode, 1);
    unlock();
    wr(UNLOCK_ADDR_A, CODE_PROGRAM);
    exp_q.push_back({2'b01, OP_PROGRAM, a, 16'hBEEF});
    wr(a, 16'hBEEF);
    // Let the launch settle into busy before the CPU reset cuts it short
    @(negedge clk_sys);
    cpu_reset = 1;
    @(negedge clk_sys);
    cpu_reset = 0;
    chk(read_mode, 1);
    repeat (30) @(negedge clk_sys);
    chk(exp_q.size(), 0);
    give_verdict();
  end
endmodule
